// file: rtl/rtcfc_pkg.sv
// rtcfc_pkg: constants and types of the clock flags/control block
// assumes a 20 MHz system clock and a byte wide register port
package rtcfc_pkg;

   typedef logic [7:0] rtcfc_byte_t;
   typedef logic [7:0] rtcfc_addr_t;

   // register offsets
   localparam rtcfc_addr_t ADDR_FLAGS   = 8'h00;
   localparam rtcfc_addr_t ADDR_SECONDS = 8'h01;
   localparam rtcfc_addr_t ADDR_MINUTES = 8'h02;
   localparam rtcfc_addr_t ADDR_SQWSEL  = 8'h03;
   localparam rtcfc_addr_t ADDR_IRQSTAT = 8'h04;
   localparam rtcfc_addr_t ADDR_IRQMASK = 8'h05;
   localparam rtcfc_addr_t ADDR_XFERSTS = 8'h06;

   // flags/control bit positions
   localparam int BIT_CAL = 2;
   localparam int BIT_WHOLD = 1;
   localparam int BIT_RHOLD = 0;

   // interrupt event bit positions
   localparam int EV_SEC = 0;
   localparam int EV_XFER = 1;
   localparam int EV_W = 2;

   // square wave select codes
   localparam logic [1:0] SEL_IRQ = 2'h0;
   localparam logic [1:0] SEL_1HZ = 2'h1;
   localparam logic [1:0] SEL_CAL = 2'h2;

   // reset values
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam rtcfc_byte_t TIME_RESET = 8'h00;
   localparam logic [EV_W:0] IRQ_RESET = 3'h0;
   localparam rtcfc_byte_t TIME_LIMIT = 8'h3b; // 59, wrap point

   // timing
   localparam int CLK_HZ = 20000000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CAL_HZ = 512;
   localparam int CLOCK_TRANSFER_TIME_NS = 1000;
   localparam int XFER_CYCLES_RAW = CLOCK_TRANSFER_TIME_NS / CLK_PERIOD_NS;
   localparam int XFER_CYCLES = (XFER_CYCLES_RAW < 1) ? 1 : XFER_CYCLES_RAW;
   localparam int HALF_SEC_CYCLES = CLK_HZ / 2;
   localparam int CAL_HALF_CYCLES = CLK_HZ / (2 * CAL_HZ);

   // transfer state machine
   typedef enum logic [1:0] {
      XS_RUN  = 2'b01,
      XS_XFER = 2'b10
   } rtcfc_xstate_e;

endpackage

// file: rtl/rtcfc_divider.sv
// rtcfc_divider: one-cycle enable pulse every DIV system clocks
// assumes a single clock domain and an asynchronous active low reset
`timescale 1ns/1ps
module rtcfc_divider #(
   parameter int DIV = 2
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   output logic      tick
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic        next_tick;

   // count down and pulse at zero
   always_comb begin
      next_tick = 1'b0;
      next_count = count - 32'h1;
      if (count == 32'h0) begin
         next_tick = 1'b1;
         next_count = 32'(DIV - 1);
      end
   end

   // register the count and pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule

// file: rtl/rtcfc_top.sv
// rtcfc_top: clock flags/control register with hold bits, transfer and calibration output
// assumes a plain register port on clk_sys; eventPin is a push-pull output pin
// Functional notes
// - calibration bit drives 512 Hz on event pin
// - calibration output overrides square wave select
// - calibration bit clears on power-up
// - write hold freezes visible time registers (running counters keep counting), allows register writes
// - releasing write hold copies changed time
// - write hold bit clears on power-up
`timescale 1ns/1ps
module rtcfc_top #(
   parameter int HALF_SEC = rtcfc_pkg::HALF_SEC_CYCLES,
   parameter int CAL_HALF = rtcfc_pkg::CAL_HALF_CYCLES
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire rtcfc_pkg::rtcfc_addr_t regAddr,
   input  wire rtcfc_pkg::rtcfc_byte_t regWdata,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output rtcfc_pkg::rtcfc_byte_t  regRdata,
   output logic                    irq,
   output logic                    eventPin
);
   import rtcfc_pkg::*;

   logic          halfTick;
   logic          calTick;
   logic          cal;
   logic          wHold;
   logic          rHold;
   logic [1:0]    sqwSel;
   logic [EV_W:0] irqStatus;
   logic [EV_W:0] irqMask;
   rtcfc_byte_t   visSec;
   rtcfc_byte_t   visMin;
   rtcfc_byte_t   runSec;
   rtcfc_byte_t   runMin;
   logic          timeDirty;
   logic          halfPhase;
   logic          sqHalf;
   logic          calSq;
   logic [7:0]    xferCnt;
   rtcfc_xstate_e xState;
   logic          next_cal;
   logic          next_wHold;
   logic          next_rHold;
   logic [1:0]    next_sqwSel;
   logic [EV_W:0] next_irqStatus;
   logic [EV_W:0] next_irqMask;
   rtcfc_byte_t   next_visSec;
   rtcfc_byte_t   next_visMin;
   rtcfc_byte_t   next_runSec;
   rtcfc_byte_t   next_runMin;
   logic          next_timeDirty;
   logic          next_halfPhase;
   logic          next_sqHalf;
   logic          next_calSq;
   logic [7:0]    next_xferCnt;
   rtcfc_xstate_e next_xState;
   rtcfc_byte_t   next_regRdata;
   logic          next_irq;
   logic          next_eventPin;
   logic          secTick;
   logic          wrFlags;
   logic          wFall;
   logic          loadRun;
   logic [EV_W:0] events;

   // wrap-around increment of a seconds or minutes value
   function automatic rtcfc_byte_t bump(input rtcfc_byte_t v);
      bump = (v >= TIME_LIMIT) ? TIME_RESET : v + 8'h01;
   endfunction

   // half second and calibration half period enables
   rtcfc_divider #(.DIV(HALF_SEC)) u_halfDiv (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (halfTick)
   );
   rtcfc_divider #(.DIV(CAL_HALF)) u_calDiv (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (calTick)
   );

   // decode of strobes
   assign secTick = halfTick & halfPhase;
   assign wrFlags = regWr && (regAddr == ADDR_FLAGS);
   assign wFall = wrFlags && wHold && !regWdata[BIT_WHOLD];
   assign loadRun = wFall && timeDirty;
   assign events[EV_SEC] = secTick;
   assign events[EV_XFER] = (xState == XS_XFER) && (xferCnt == 8'h0) && !loadRun;
   assign events[EV_W] = wFall;

   // control registers, interrupt status and mask
   always_comb begin
      next_cal = cal;
      next_wHold = wHold;
      next_rHold = rHold;
      next_sqwSel = sqwSel;
      next_irqMask = irqMask;
      next_irqStatus = irqStatus;
      if (wrFlags) begin
         next_cal = regWdata[BIT_CAL];
         next_wHold = regWdata[BIT_WHOLD];
         next_rHold = regWdata[BIT_RHOLD];
      end
      if (regWr && regAddr == ADDR_SQWSEL)
         next_sqwSel = regWdata[1:0];
      if (regWr && regAddr == ADDR_IRQMASK)
         next_irqMask = regWdata[EV_W:0];
      if (regWr && regAddr == ADDR_IRQSTAT)
         next_irqStatus = irqStatus & ~regWdata[EV_W:0];
      next_irqStatus = next_irqStatus | events; // a new event beats its clear
      next_irq = |(next_irqStatus & next_irqMask);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cal <= 1'b0;
         wHold <= 1'b0;
         rHold <= 1'b0;
         sqwSel <= SEL_RESET;
         irqMask <= IRQ_RESET;
         irqStatus <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         cal <= next_cal;
         wHold <= next_wHold;
         rHold <= next_rHold;
         sqwSel <= next_sqwSel;
         irqMask <= next_irqMask;
         irqStatus <= next_irqStatus;
         irq <= next_irq;
      end
   end

   // running counters, visible registers and the transfer sequence
   always_comb begin
      next_runSec = runSec;
      next_runMin = runMin;
      next_visSec = visSec;
      next_visMin = visMin;
      next_timeDirty = timeDirty;
      next_xState = xState;
      next_xferCnt = xferCnt;
      next_halfPhase = halfTick ? !halfPhase : halfPhase;
      if (secTick) begin
         next_runSec = bump(runSec);
         if (runSec >= TIME_LIMIT)
            next_runMin = bump(runMin);
      end
      unique case (xState)
         XS_RUN: begin
            if (loadRun) begin
               next_runSec = visSec;
               next_runMin = visMin;
               next_timeDirty = 1'b0;
               next_xState = XS_XFER;
               next_xferCnt = 8'(XFER_CYCLES - 1);
            end
         end
         XS_XFER: begin
            if (loadRun) begin
               // a new release with changed time restarts the copy rather than losing it
               next_runSec = visSec;
               next_runMin = visMin;
               next_timeDirty = 1'b0;
               next_xferCnt = 8'(XFER_CYCLES - 1);
            end else if (xferCnt == 8'h0)
               next_xState = XS_RUN;
            else
               next_xferCnt = xferCnt - 8'h01;
         end
      endcase
      if (wHold) begin
         // clock frozen for software, time registers writable
         if (regWr && regAddr == ADDR_SECONDS) begin
            next_visSec = regWdata;
            next_timeDirty = 1'b1;
         end
         if (regWr && regAddr == ADDR_MINUTES) begin
            next_visMin = regWdata;
            next_timeDirty = 1'b1;
         end
      end else if (!rHold && xState == XS_RUN && !loadRun) begin
         next_visSec = next_runSec;
         next_visMin = next_runMin;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         runSec <= TIME_RESET;
         runMin <= TIME_RESET;
         visSec <= TIME_RESET;
         visMin <= TIME_RESET;
         timeDirty <= 1'b0;
         xState <= XS_RUN;
         xferCnt <= 8'h0;
         halfPhase <= 1'b0;
      end else begin
         runSec <= next_runSec;
         runMin <= next_runMin;
         visSec <= next_visSec;
         visMin <= next_visMin;
         timeDirty <= next_timeDirty;
         xState <= next_xState;
         xferCnt <= next_xferCnt;
         halfPhase <= next_halfPhase;
      end
   end

   // square waves and event pin selection
   always_comb begin
      next_sqHalf = halfTick ? !sqHalf : sqHalf;
      next_calSq = calTick ? !calSq : calSq;
      if (cal)
         next_eventPin = next_calSq;
      else begin
         unique case (sqwSel)
            SEL_IRQ: next_eventPin = next_irq;
            SEL_1HZ: next_eventPin = next_sqHalf;
            SEL_CAL: next_eventPin = next_calSq;
            default: next_eventPin = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sqHalf <= 1'b0;
         calSq <= 1'b0;
         eventPin <= 1'b0;
      end else begin
         sqHalf <= next_sqHalf;
         calSq <= next_calSq;
         eventPin <= next_eventPin;
      end
   end

   // read data, valid only in the cycle after the read strobe
   always_comb begin
      next_regRdata = 8'h00;
      if (regRd) begin
         unique case (regAddr)
            ADDR_FLAGS:   next_regRdata = {5'h00, cal, wHold, rHold};
            ADDR_SECONDS: next_regRdata = visSec;
            ADDR_MINUTES: next_regRdata = visMin;
            ADDR_SQWSEL:  next_regRdata = {6'h00, sqwSel};
            ADDR_IRQSTAT: next_regRdata = {5'h00, irqStatus};
            ADDR_IRQMASK: next_regRdata = {5'h00, irqMask};
            ADDR_XFERSTS: next_regRdata = {7'h00, xState == XS_XFER};
            default:      next_regRdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         regRdata <= 8'h00;
      else
         regRdata <= next_regRdata;
   end

   // helper: high from the first edge after reset release
   logic seenClk;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         seenClk <= 1'b0;
      else
         seenClk <= 1'b1;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_cal_wave_drive: assert property ($past(cal) |-> eventPin == calSq)
      else $error("event pin does not follow calibration wave");
   chk_cal_over_select: assert property (cal && sqwSel != SEL_CAL && calTick |=> eventPin == calSq)
      else $error("square wave select not overridden by calibration");
   chk_pin_normal: assert property (!$past(cal) && $past(sqwSel) == SEL_IRQ |-> eventPin == irq)
      else $error("event pin not back on interrupt when calibration off");
   chk_cal_reset: assert property (!seenClk |-> !cal)
      else $error("calibration bit not clear after reset");
   chk_whold_reset: assert property (!seenClk |-> !wHold && xState == XS_RUN)
      else $error("write hold not clear after reset");
   chk_hold_freeze: assert property (wHold && $past(wHold) && !$past(regWr) |-> $stable(visSec) && $stable(visMin))
      else $error("visible time moved under write hold");
   chk_hold_write: assert property (wHold && regWr && regAddr == ADDR_SECONDS |=> visSec == $past(regWdata))
      else $error("seconds write under hold not accepted");
   chk_xfer_copy: assert property (loadRun |=> runSec == $past(visSec) && runMin == $past(visMin) ##[1:20]
                                   xState == XS_RUN)
      else $error("transfer did not copy time or did not end in time");
   chk_snap_freeze: assert property (rHold && $past(rHold) && !$past(wHold) |-> $stable(visSec))
      else $error("visible time moved under read hold");
   chk_irq_level: assert property (irq == |(irqStatus & irqMask))
      else $error("interrupt level disagrees with status and mask");
   chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data not zero outside the read answer cycle");

   cov_cal_on: cover property (cal && calTick ##1 eventPin);
   cov_time_load: cover property (loadRun ##1 xState == XS_XFER);
   cov_read_hold: cover property (rHold && secTick);
   cov_pin_irq: cover property (!cal && sqwSel == SEL_IRQ && irq ##1 eventPin);
endmodule

// file: testbench/rtcfc_top_tb_top.sv
// rtcfc_top_tb_top: register-level bench for the clock flags/control block
// assumes rtcfc_pkg is compiled first; second and calibration dividers are shortened
`timescale 1ns/1ps
module rtcfc_top_tb_top;
   import rtcfc_pkg::*;

   localparam int HALF = 10;
   localparam int CALH = 3;

   logic        clk_sys;
   logic        rst_n;
   rtcfc_addr_t regAddr;
   rtcfc_byte_t regWdata;
   logic        regWr;
   logic        regRd;
   rtcfc_byte_t regRdata;
   logic        irq;
   logic        eventPin;
   int          failures;
   int          compares;
   rtcfc_byte_t rv;
   rtcfc_byte_t s0;
   int          n;

   rtcfc_top #(.HALF_SEC(HALF), .CAL_HALF(CALH)) dut (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .regAddr  (regAddr),
      .regWdata (regWdata),
      .regWr    (regWr),
      .regRd    (regRd),
      .regRdata (regRdata),
      .irq      (irq),
      .eventPin (eventPin)
   );

   // 20 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // one comparison, reported at once on mismatch
   task automatic check(input rtcfc_byte_t got, input rtcfc_byte_t exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input rtcfc_addr_t a, input rtcfc_byte_t d);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk_sys);
      regWr    <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input rtcfc_addr_t a, output rtcfc_byte_t d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk_sys);
      regRd   <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_sys);
   endtask

   // cycles between two changes of the event pin, bounded
   task automatic halfPeriod(output int c);
      int   k;
      logic last;
      k = 0;
      c = 0;
      // let the new selection reach the pin, so the sync edge below is a real wave edge
      repeat (2) @(posedge clk_sys);
      #1;
      last = eventPin;
      while (eventPin === last && k < 100) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      last = eventPin;
      while (eventPin === last && c < 100) begin
         @(posedge clk_sys);
         #1;
         c++;
      end
      if (k >= 100 || c >= 100) begin
         failures++;
         $display("[FAIL] %0t event pin edge wait timed out", $time);
      end
   endtask

   // verdict and end of run
   task automatic results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_n    = 1'b0;
      regAddr  = '0;
      regWdata = '0;
      regWr    = 1'b0;
      regRd    = 1'b0;
      failures = 0;
      compares = 0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      check({7'h0, eventPin}, 8'h00, "pin after reset");
      check({7'h0, irq}, 8'h00, "irq after reset");
      rd(ADDR_FLAGS, rv);
      check(rv, 8'h00, "flags after reset");
      rd(8'h20, rv);
      check(rv, 8'h00, "unmapped read");
      // calibration square wave wins over every select code
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_SQWSEL, 8'(s));
         wr(ADDR_FLAGS, 8'h04);
         halfPeriod(n);
         check(8'(n), 8'(CALH), "cal half period");
      end
      rd(ADDR_FLAGS, rv);
      check(rv, 8'h04, "cal bit readback");
      wr(ADDR_FLAGS, 8'h00);
      idle(2);
      #1;
      check({7'h0, eventPin}, 8'h00, "pin back to select 3");
      idle(CALH);
      #1;
      check({7'h0, eventPin}, 8'h00, "pin stays low");
      wr(ADDR_SQWSEL, 8'h01);
      halfPeriod(n);
      check(8'(n), 8'(HALF), "one hertz half period");
      wr(ADDR_SQWSEL, 8'h02);
      halfPeriod(n);
      check(8'(n), 8'(CALH), "selected calibration rate");
      // write hold: freeze, load new time, release
      wr(ADDR_IRQMASK, 8'h02);
      wr(ADDR_FLAGS, 8'h02);
      rd(ADDR_SECONDS, s0);
      idle(4 * HALF);
      rd(ADDR_SECONDS, rv);
      check(rv, s0, "seconds frozen by write hold");
      wr(ADDR_SECONDS, 8'h30);
      wr(ADDR_MINUTES, 8'h05);
      rd(ADDR_SECONDS, rv);
      check(rv, 8'h30, "seconds written under hold");
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_XFERSTS, rv);
      check(rv, 8'h01, "transfer busy");
      idle(XFER_CYCLES);
      rd(ADDR_XFERSTS, rv);
      check(rv, 8'h00, "transfer finished");
      check({7'h0, irq}, 8'h01, "transfer done interrupt");
      wr(ADDR_SQWSEL, 8'h00);
      idle(1);
      #1;
      check({7'h0, eventPin}, 8'h01, "pin shows interrupt");
      rd(ADDR_MINUTES, rv);
      check(rv, 8'h05, "minutes transferred");
      rd(ADDR_SECONDS, rv);
      check({7'h0, rv >= 8'h30 && rv <= 8'h32}, 8'h01, "seconds run from new base");
      wr(ADDR_IRQSTAT, 8'h02);
      idle(2);
      #1;
      check({7'h0, irq}, 8'h00, "interrupt cleared, tick masked");
      check({7'h0, eventPin}, 8'h00, "pin follows cleared interrupt");
      // read hold: visible seconds stop, time write refused without write hold
      wr(ADDR_FLAGS, 8'h01);
      rd(ADDR_SECONDS, s0);
      wr(ADDR_SECONDS, 8'h3a);
      idle(4 * HALF);
      rd(ADDR_SECONDS, rv);
      check(rv, s0, "seconds frozen by read hold");
      wr(ADDR_FLAGS, 8'h00);
      idle(4 * HALF);
      rd(ADDR_SECONDS, rv);
      check({7'h0, rv != s0}, 8'h01, "seconds resume");
      results;
   end

   // hang guard
   initial begin
      #(50 * 20000);
      failures++;
      $display("[FAIL] %0t run timed out", $time);
      results;
   end

endmodule
